// *** hw/rtpw_top.v ***
// Radio transmit control: calibration, power, bias switch and test modes
`include "rtpw_map.vh"
`default_nettype none

module rtpw_top (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Crystal oscillator
  output reg osc_enable,
  input wire osc_ready,
  // Channel assessment from receiver
  input wire cca_clear,
  // Synthesizer calibration
  output wire synth_cal_active,
  // Analog front end
  output reg [4:0] amp_power_level,
  output reg rx_tx_bias_switch,
  output wire tx_enable,
  output wire rx_enable,
  output wire dac_override_active,
  output reg [15:0] dac_override_word,
  // Byte stream to modulator
  input wire tx_byte_req,
  output reg [7:0] tx_data,
  output reg tx_data_strobe
);

  // ----------------------------------------------------------------------
  // Radio states
  // ----------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX_CAL = 5'h02;
  localparam [4:0] ST_RX = 5'h04;
  localparam [4:0] ST_TX_CAL = 5'h08;
  localparam [4:0] ST_TX = 5'h10;
  localparam [31:0] CAL_LAST_W = `RTPW_CAL_CYCLES - 1;
  localparam [11:0] CAL_LAST = CAL_LAST_W[11:0];
  localparam [3:0] HDR_LAST = `RTPW_PREAMBLE_BYTES;

  reg [4:0] state_q;
  reg [11:0] cal_cnt_q;
  reg [7:0] tx_control_low_q;
  reg [7:0] modem_control1_low_q;
  reg [7:0] dac_override_high_q;
  reg [7:0] dac_override_low_q;
  reg osc_meta_q;
  reg osc_sync_q;
  reg cca_meta_q;
  reg cca_sync_q;
  reg underflow_q;
  reg [3:0] hdr_cnt_q;
  reg [7:0] buf_mem [0:`RTPW_BUF_DEPTH-1];
  reg [6:0] wr_ptr_q;
  reg [6:0] rd_ptr_q;
  reg [7:0] count_q;
  reg [7:0] count_d;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  reg [31:0] rd_val;
  reg hit;

  wire [1:0] tx_mode = modem_control1_low_q[`RTPW_MODE_MSB:0];
  wire [15:0] dac_word = {dac_override_high_q, dac_override_low_q};
  wire carrier_cfg = (tx_mode == `RTPW_MODE_FIFO_OR_CARRIER) &&
                     (dac_word != 16'h0000);
  wire replay_cfg = (tx_mode == `RTPW_MODE_FIFO_OR_CARRIER) &&
                    (dac_word == 16'h0000);
  wire prbs_cfg = (tx_mode == `RTPW_MODE_PRBS);

  wire stb_wr = wr_en && (paddr == `RTPW_OFS_STROBE);
  wire stb_osc_on = stb_wr & pwdata[`RTPW_STB_OSC_ON];
  wire stb_rx_on = stb_wr & pwdata[`RTPW_STB_RX_ON];
  wire stb_tx_on = stb_wr & pwdata[`RTPW_STB_TX_ON];
  wire stb_tx_cca = stb_wr & pwdata[`RTPW_STB_TX_ON_IF_CLEAR];
  wire stb_off = stb_wr & pwdata[`RTPW_STB_RADIO_OFF];
  // Clear-channel strobe is dropped when the channel is busy
  wire tx_start = stb_tx_on | (stb_tx_cca & cca_sync_q);
  wire buf_push = wr_en && (paddr == `RTPW_OFS_TX_BUFFER) &&
                  (count_q != `RTPW_BUF_FULL);

  wire [15:0] crc_word;
  wire in_tx = (state_q == ST_TX);
  wire hdr_done = (hdr_cnt_q > HDR_LAST);
  wire byte_take = in_tx & tx_byte_req;
  wire buf_empty = (count_q == 8'h00);
  wire prbs_step = byte_take & hdr_done & prbs_cfg;
  // Replay keeps reading the whole buffer whether or not it drained
  wire buf_pop = byte_take & hdr_done & ~carrier_cfg & ~prbs_cfg &
                 (replay_cfg | ~buf_empty);

  always @* begin
    rd_val = 32'h00000000;
    hit = 1'b1;
    if (paddr == `RTPW_OFS_TX_CONTROL_LOW) begin
      rd_val = {24'h000000, tx_control_low_q};
    end else if (paddr == `RTPW_OFS_MODEM_CONTROL1_LOW) begin
      rd_val = {24'h000000, modem_control1_low_q};
    end else if (paddr == `RTPW_OFS_DAC_OVERRIDE_HIGH) begin
      rd_val = {24'h000000, dac_override_high_q};
    end else if (paddr == `RTPW_OFS_DAC_OVERRIDE_LOW) begin
      rd_val = {24'h000000, dac_override_low_q};
    end else if (paddr == `RTPW_OFS_STROBE) begin
      rd_val = 32'h00000000;
    end else if (paddr == `RTPW_OFS_STATUS) begin
      rd_val[`RTPW_ST_OSC_STABLE] = osc_sync_q;
      rd_val[`RTPW_ST_TX_ACTIVE] = in_tx;
      rd_val[`RTPW_ST_RX_ACTIVE] = (state_q == ST_RX);
      rd_val[`RTPW_ST_CALIBRATING] = synth_cal_active;
      rd_val[`RTPW_ST_UNDERFLOW] = underflow_q;
      rd_val[`RTPW_ST_OSC_ENABLED] = osc_enable;
    end else if (paddr == `RTPW_OFS_TX_BUFFER) begin
      rd_val = {24'h000000, count_q};
    end else begin
      hit = 1'b0;
    end
  end

  // One wait-free access phase; answer is captured in the setup cycle
  assign pready = penable;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= ~hit;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      cca_meta_q <= 1'b0;
      cca_sync_q <= 1'b0;
    end else begin
      osc_meta_q <= osc_ready;
      osc_sync_q <= osc_meta_q;
      cca_meta_q <= cca_clear;
      cca_sync_q <= cca_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_control_low_q <= `RTPW_RST_TX_CONTROL_LOW;
      modem_control1_low_q <= `RTPW_RST_MODEM_CONTROL1_LOW;
      dac_override_high_q <= `RTPW_RST_DAC_OVERRIDE;
      dac_override_low_q <= `RTPW_RST_DAC_OVERRIDE;
      osc_enable <= 1'b0;
    end else begin
      if (wr_en && paddr == `RTPW_OFS_TX_CONTROL_LOW) begin
        tx_control_low_q <= pwdata[7:0];
      end
      if (wr_en && paddr == `RTPW_OFS_MODEM_CONTROL1_LOW) begin
        modem_control1_low_q <= pwdata[7:0];
      end else if (stb_off) begin
        modem_control1_low_q[`RTPW_MODE_MSB:0] <= `RTPW_MODE_NORMAL;
      end
      if (wr_en && paddr == `RTPW_OFS_DAC_OVERRIDE_HIGH) begin
        dac_override_high_q <= pwdata[7:0];
      end
      if (wr_en && paddr == `RTPW_OFS_DAC_OVERRIDE_LOW) begin
        dac_override_low_q <= pwdata[7:0];
      end
      if (stb_osc_on) begin
        osc_enable <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Radio control state machine
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cal_cnt_q <= 12'h000;
    end else if (stb_off) begin
      state_q <= ST_IDLE;
      cal_cnt_q <= 12'h000;
    end else begin
      case (state_q)
        ST_IDLE, ST_RX: begin
          cal_cnt_q <= 12'h000;
          if (tx_start) begin
            state_q <= ST_TX_CAL;
          end else if (stb_rx_on && state_q == ST_IDLE) begin
            state_q <= ST_RX_CAL;
          end
        end
        ST_RX_CAL: begin
          cal_cnt_q <= cal_cnt_q + 12'h001;
          if (cal_cnt_q == CAL_LAST) begin
            state_q <= ST_RX;
          end
        end
        ST_TX_CAL: begin
          cal_cnt_q <= cal_cnt_q + 12'h001;
          if (cal_cnt_q == CAL_LAST) begin
            state_q <= ST_TX;
          end
        end
        ST_TX: begin
          cal_cnt_q <= 12'h000;
          // Normal frames end when the buffer runs dry
          if (byte_take && hdr_done && tx_mode == `RTPW_MODE_NORMAL &&
              buf_empty) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cal_cnt_q <= 12'h000;
        end
      endcase
    end
  end

  assign synth_cal_active = (state_q == ST_RX_CAL) | (state_q == ST_TX_CAL);
  assign tx_enable = in_tx;
  assign rx_enable = (state_q == ST_RX);
  assign dac_override_active = in_tx & carrier_cfg;

  // ----------------------------------------------------------------------
  // Front end drive
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      amp_power_level <= 5'h1F;
      rx_tx_bias_switch <= 1'b0;
      dac_override_word <= 16'h0000;
    end else begin
      amp_power_level <= tx_control_low_q[`RTPW_PWR_MSB:0];
      rx_tx_bias_switch <= (state_q == ST_TX_CAL) | in_tx;
      dac_override_word <= carrier_cfg ? dac_word : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------------
  always @* begin
    count_d = count_q;
    if (buf_push && !(buf_pop && !replay_cfg)) begin
      count_d = count_q + 8'h01;
    end else if (!buf_push && buf_pop && !replay_cfg) begin
      count_d = count_q - 8'h01;
    end
  end

  always @(posedge core_clk) begin
    if (buf_push) begin
      buf_mem[wr_ptr_q] <= pwdata[7:0];
    end
  end

  // Replay does not consume, so the same 128 bytes recur
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
      count_q <= 8'h00;
    end else begin
      if (buf_push) begin
        wr_ptr_q <= wr_ptr_q + 7'h01;
      end
      if (buf_pop) begin
        rd_ptr_q <= rd_ptr_q + 7'h01;
      end
      count_q <= count_d;
    end
  end

  // Underflow is only reported in normal mode
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      underflow_q <= 1'b0;
    end else if (byte_take && hdr_done && tx_mode == `RTPW_MODE_NORMAL &&
                 buf_empty) begin
      underflow_q <= 1'b1;
    end else if (tx_start) begin
      underflow_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Byte source: header, then buffer or pattern
  // ----------------------------------------------------------------------
  wire gen_clear = (state_q == ST_TX_CAL);

  rtpw_crc16 u_crc (
    .core_clk(core_clk),
    .nrst(nrst),
    .clear(gen_clear),
    .step(prbs_step),
    .data(`RTPW_PRBS_FEED),
    .crc(crc_word)
  );

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hdr_cnt_q <= 4'h0;
      tx_data <= 8'h00;
      tx_data_strobe <= 1'b0;
    end else begin
      tx_data_strobe <= 1'b0;
      if (gen_clear) begin
        hdr_cnt_q <= 4'h0;
      end else if (byte_take) begin
        if (!hdr_done) begin
          // Header goes out in every mode, test modes too
          hdr_cnt_q <= hdr_cnt_q + 4'h1;
          tx_data <= (hdr_cnt_q == HDR_LAST) ? `RTPW_SFD_BYTE :
                     `RTPW_PREAMBLE_BYTE;
          tx_data_strobe <= 1'b1;
        end else if (prbs_cfg) begin
          // Low byte before the advance gives 00 78 B8 ...
          tx_data <= crc_word[7:0];
          tx_data_strobe <= 1'b1;
        end else if (buf_pop) begin
          tx_data <= buf_mem[rd_ptr_q];
          tx_data_strobe <= 1'b1;
        end
      end
    end
  end

  // The CRC pattern period of 65535 bits follows from the generator
  // polynomial and the fixed 0xFF feed; nothing here truncates it.

endmodule

`default_nettype wire

// *** hw/rtpw_map.vh ***
// Register map, field positions and timing constants for the radio tx block
//
// Overview of operation
// - Calibrate synthesizer on every receive or transmit enable
// - Amplifier drive follows power level field
// - Bias switch low receiving, high transmitting
// - Carrier mode forces static DAC override values
// - Mode 3 plus tx strobe sends pseudorandom
// - Send CRC low byte, then feed 0xFF
// - Pseudorandom sequence repeats every 65535 bits
// - Payload starts 00 78 B8 4B 99 C3 E9
// - Preamble and delimiter precede data in every mode
// - Mode 2 without override replays buffer, ignores underflow
// - Oscillator stable flag readable by software
`ifndef RTPW_MAP_VH
`define RTPW_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RTPW_OFS_TX_CONTROL_LOW 12'h000
`define RTPW_OFS_MODEM_CONTROL1_LOW 12'h004
`define RTPW_OFS_DAC_OVERRIDE_HIGH 12'h008
`define RTPW_OFS_DAC_OVERRIDE_LOW 12'h00C
`define RTPW_OFS_STROBE 12'h010
`define RTPW_OFS_STATUS 12'h014
`define RTPW_OFS_TX_BUFFER 12'h018

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RTPW_RST_TX_CONTROL_LOW 8'hFF
`define RTPW_RST_MODEM_CONTROL1_LOW 8'h00
`define RTPW_RST_DAC_OVERRIDE 8'h00

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define RTPW_PWR_MSB 4
`define RTPW_MODE_MSB 1
`define RTPW_MODE_NORMAL 2'h0
`define RTPW_MODE_FIFO_OR_CARRIER 2'h2
`define RTPW_MODE_PRBS 2'h3
`define RTPW_STB_OSC_ON 0
`define RTPW_STB_RX_ON 1
`define RTPW_STB_TX_ON 2
`define RTPW_STB_TX_ON_IF_CLEAR 3
`define RTPW_STB_RADIO_OFF 4
`define RTPW_ST_OSC_STABLE 0
`define RTPW_ST_TX_ACTIVE 1
`define RTPW_ST_RX_ACTIVE 2
`define RTPW_ST_CALIBRATING 3
`define RTPW_ST_UNDERFLOW 4
`define RTPW_ST_OSC_ENABLED 5

// ----------------------------------------------------------------------
// Frame and buffer constants
// ----------------------------------------------------------------------
`define RTPW_PREAMBLE_BYTES 4'h4
`define RTPW_PREAMBLE_BYTE 8'h00
`define RTPW_SFD_BYTE 8'hA7
`define RTPW_PRBS_FEED 8'hFF
`define RTPW_CRC_INIT 16'h0000
`define RTPW_CRC_POLY 16'h8408
`define RTPW_BUF_DEPTH 128
`define RTPW_BUF_FULL 8'h80

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTPW_CLK_MHZ 100
`define RTPW_CAL_TIME_US 12
`define RTPW_CAL_CYCLES (`RTPW_CAL_TIME_US * `RTPW_CLK_MHZ)

`endif

// *** hw/rtpw_crc16.v ***
// Byte-wide frame CRC generator used as the test pattern source
`include "rtpw_map.vh"
`default_nettype none

module rtpw_crc16 (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Control
  input wire clear,
  input wire step,
  input wire [7:0] data,
  // State
  output wire [15:0] crc
);

  reg [15:0] crc_q;
  reg [15:0] crc_d;
  integer i;

  // ----------------------------------------------------------------------
  // Bitwise update, least significant bit first
  // ----------------------------------------------------------------------
  always @* begin
    crc_d = crc_q;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_d[0] ^ data[i]) begin
        crc_d = {1'b0, crc_d[15:1]} ^ `RTPW_CRC_POLY;
      end else begin
        crc_d = {1'b0, crc_d[15:1]};
      end
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc_q <= `RTPW_CRC_INIT;
    end else if (clear) begin
      crc_q <= `RTPW_CRC_INIT;
    end else if (step) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule

`default_nettype wire

// *** dv/rtpw_top_props.sv ***
// Concurrent checks on the ports of the radio transmit control block
`default_nettype none
module rtpw_top_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Front end
  input wire logic synth_cal_active,
  input wire logic [4:0] amp_power_level,
  input wire logic rx_tx_bias_switch,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic dac_override_active,
  input wire logic [15:0] dac_override_word,
  // Byte stream
  input wire logic tx_byte_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // --------------------------------------------------------------------
  // Helper state
  // --------------------------------------------------------------------
  wire bus_wr = psel && penable && pwrite;
  wire off_wr = bus_wr && paddr == 12'h010 && pwdata[4];
  logic [3:0] cnt_q;
  logic [1:0] mode_q;

  // Byte count restarts each time the transmitter is entered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      mode_q <= 2'h0;
    end else begin
      if (!tx_enable)
        cnt_q <= 4'h0;
      else if (tx_data_strobe && cnt_q != 4'hF)
        cnt_q <= cnt_q + 4'h1;
      if (bus_wr && paddr == 12'h004)
        mode_q <= pwdata[1:0];
      else if (off_wr)
        mode_q <= 2'h0;
    end
  end

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  sequence s_at(int n);
    tx_data_strobe && tx_enable && cnt_q == n;
  endsequence
  sequence s_lead;
    tx_data_strobe && tx_enable && cnt_q < 4'h4;
  endsequence
  sequence s_pay(int n);
    s_at(n) ##0 mode_q == 2'h3;
  endsequence

  AST_CAL_HOLD:
    assert property ($rose(synth_cal_active) |-> synth_cal_active[*8])
    else $error("calibration ended too early");
  AST_CAL_FIRST:
    assert property ($rose(tx_enable) |-> $past(synth_cal_active))
    else $error("transmit entered without calibration");
  AST_PWR:
    assert property (bus_wr && paddr == 12'h000 |->
      ##2 amp_power_level == $past(pwdata[4:0], 2))
    else $error("power level does not follow control byte");
  AST_BIAS_TX:
    assert property (tx_enable |-> rx_tx_bias_switch)
    else $error("bias switch low while transmitting");
  AST_BIAS_RX:
    assert property (rx_enable |-> !rx_tx_bias_switch)
    else $error("bias switch high while receiving");
  AST_DAC_TX:
    assert property (dac_override_active |->
      tx_enable && dac_override_word != 16'h0000)
    else $error("override active outside carrier transmit");
  AST_STB_LAG:
    assert property (tx_data_strobe |-> $past(tx_byte_req && tx_enable))
    else $error("byte strobe without a request");
  AST_PRBS_ANS:
    assert property (tx_byte_req && tx_enable && mode_q == 2'h3 && !off_wr
      |=> tx_data_strobe)
    else $error("pattern byte not supplied");
  AST_HDR_ZERO:
    assert property (s_lead |-> tx_data == 8'h00)
    else $error("preamble byte wrong");
  AST_HDR_SFD:
    assert property (s_at(4) |-> tx_data == 8'hA7)
    else $error("delimiter byte wrong");
  AST_PRBS_FIRST:
    assert property (s_pay(5) |-> tx_data == 8'h00)
    else $error("first pattern byte wrong");
  AST_PRBS_NEXT:
    assert property (s_pay(6) |-> tx_data == 8'h78)
    else $error("second pattern byte wrong");
endmodule

bind rtpw_top rtpw_top_props u_rtpw_top_props (.core_clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .synth_cal_active, .amp_power_level,
  .rx_tx_bias_switch, .tx_enable, .rx_enable, .dac_override_active,
  .dac_override_word, .tx_byte_req, .tx_data, .tx_data_strobe);
`default_nettype wire

// *** dv/rtpw_afe_model.sv ***
// Model of the crystal oscillator and modulator beside the radio block
`default_nettype none
module rtpw_afe_model #(
  parameter int OSC_START = 40
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Oscillator
  input wire logic osc_enable,
  output logic osc_ready,
  // Modulator
  input wire logic tx_enable,
  input wire logic [7:0] gap,
  output logic tx_byte_req
);
  timeunit 1ns;
  timeprecision 1ps;
  int osc_cnt_q;
  logic [7:0] gap_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_q <= 0;
      osc_ready <= 1'b0;
      tx_byte_req <= 1'b0;
      gap_q <= 8'h00;
    end else begin
      // Stable only after a start-up delay, never at once
      if (!osc_enable)
        osc_cnt_q <= 0;
      else if (osc_cnt_q < OSC_START)
        osc_cnt_q <= osc_cnt_q + 1;
      osc_ready <= osc_enable && osc_cnt_q == OSC_START;
      // Gap of at least one keeps each request a single-cycle pulse
      if (tx_enable && gap_q == 8'h00) begin
        tx_byte_req <= 1'b1;
        gap_q <= gap;
      end else begin
        tx_byte_req <= 1'b0;
        if (gap_q != 8'h00)
          gap_q <= gap_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/test_radio_tx_power_and_test_modes.sv ***
// Self-checking bench for the radio transmit control block
`default_nettype none
module test_radio_tx_power_and_test_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, cca_clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic osc_enable, osc_ready, synth_cal_active, rx_tx_bias_switch;
  logic tx_enable, rx_enable, dac_override_active, tx_byte_req;
  logic tx_data_strobe;
  logic [4:0] amp_power_level;
  logic [15:0] dac_override_word;
  logic [7:0] tx_data, gap, b;
  logic [7:0] buf_b [128];
  logic [7:0] pat [7] = '{8'h00, 8'h78, 8'hB8, 8'h4B, 8'h99, 8'hC3, 8'hE9};
  logic [32:0] rd_q [$];
  logic [7:0] exp_q [$];
  int n_errors, checked, i, k;
  bit strict;

  rtpw_top u_rtpw_top (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .osc_enable, .osc_ready, .cca_clear,
    .synth_cal_active, .amp_power_level, .rx_tx_bias_switch, .tx_enable,
    .rx_enable, .dac_override_active, .dac_override_word, .tx_byte_req,
    .tx_data, .tx_data_strobe);
  rtpw_afe_model u_rtpw_afe_model (.core_clk, .nrst, .osc_enable,
    .osc_ready, .tx_enable, .gap, .tx_byte_req);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task hdr();
    repeat (4) exp_q.push_back(8'h00);
    exp_q.push_back(8'hA7);
  endtask
  task wait_tx(input logic v);
    for (k = 0; k < 3000 && tx_enable !== v; k++) @(posedge core_clk);
    chk(tx_enable, v);
  endtask
  task drain();
    for (k = 0; k < 9000 && exp_q.size() != 0; k++) @(posedge core_clk);
    chk(exp_q.size() == 0, 1);
  endtask
  task wrap_up();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Unexpected strobes are only tolerated once a test relaxes strict
  always @(posedge core_clk) begin
    if (tx_data_strobe === 1'b1) begin
      if (exp_q.size() != 0)
        chk({25'h0, tx_data}, {25'h0, exp_q.pop_front()});
      else if (strict)
        chk({25'h0, tx_data}, 33'h1FF);
    end
    if (psel && penable && pready && !pwrite && rd_q.size() != 0)
      chk({pslverr, prdata}, rd_q.pop_front());
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {nrst, psel, penable, pwrite, cca_clear} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    gap = 8'h02;
    strict = 1'b1;
    n_errors = 0;
    checked = 0;
    void'($urandom(45469));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk(amp_power_level, 33'd31);
    rd(12'h000, 33'hFF);
    rd(12'h004, 33'h0);
    rd(12'h01C, 33'h1_0000_0000);
    $display("test reset done");
    apb(1'b1, 12'h010, 32'h1);
    for (k = 0; k < 500 && osc_ready !== 1'b1; k++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    rd(12'h014, 33'h21);
    $display("test oscillator done");
    for (i = 32; i >= 0; i -= 4) begin
      b = (i == 0) ? 8'($urandom) : 8'(i - 1);
      apb(1'b1, 12'h000, {27'h7, b[4:0]});
      repeat (2) @(posedge core_clk);
      chk(amp_power_level, b[4:0]);
    end
    $display("test power done");
    apb(1'b1, 12'h010, 32'h8);
    repeat (20) @(posedge core_clk);
    rd(12'h014, 33'h21);
    apb(1'b1, 12'h004, 32'h3);
    gap <= 8'($urandom_range(12, 3));
    hdr();
    for (i = 0; i < 7; i++) exp_q.push_back(pat[i]);
    cca_clear <= 1'b1;
    repeat (3) @(posedge core_clk);
    apb(1'b1, 12'h010, 32'h8);
    chk(synth_cal_active, 1);
    wait_tx(1'b1);
    chk(rx_tx_bias_switch, 1);
    strict = 1'b0;
    drain();
    rd(12'h004, 33'h3);
    apb(1'b1, 12'h010, 32'h10);
    wait_tx(1'b0);
    repeat (3) @(posedge core_clk);
    strict = 1'b1;
    rd(12'h004, 33'h0);
    $display("test pattern done");
    apb(1'b1, 12'h010, 32'h2);
    for (k = 0; k < 3000 && rx_enable !== 1'b1; k++) @(posedge core_clk);
    chk(rx_tx_bias_switch, 0);
    chk(rx_enable, 1);
    apb(1'b1, 12'h010, 32'h10);
    $display("test receive done");
    apb(1'b1, 12'h008, 32'h18);
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b1, 12'h004, 32'h2);
    hdr();
    apb(1'b1, 12'h010, 32'h4);
    wait_tx(1'b1);
    chk(dac_override_active, 1);
    chk(dac_override_word, 33'h1800);
    repeat (200) @(posedge core_clk);
    chk(exp_q.size() == 0, 1);
    apb(1'b1, 12'h010, 32'h10);
    repeat (3) @(posedge core_clk);
    $display("test carrier done");
    apb(1'b1, 12'h008, 32'h0);
    for (i = 0; i < 128; i++) begin
      buf_b[i] = 8'($urandom);
      apb(1'b1, 12'h018, {24'h0, buf_b[i]});
    end
    apb(1'b1, 12'h018, 32'h5A);
    rd(12'h018, 33'h80);
    apb(1'b1, 12'h004, 32'h2);
    hdr();
    for (i = 0; i < 133; i++) exp_q.push_back(buf_b[i % 128]);
    apb(1'b1, 12'h010, 32'h4);
    wait_tx(1'b1);
    strict = 1'b0;
    drain();
    rd(12'h014, 33'h23);
    apb(1'b1, 12'h010, 32'h10);
    // Let a trailing replay strobe pass before new notes are queued
    repeat (3) @(posedge core_clk);
    $display("test replay done");
    // Mode field is back to normal: the full buffer drains, then underflow
    hdr();
    apb(1'b1, 12'h010, 32'h4);
    wait_tx(1'b1);
    drain();
    wait_tx(1'b0);
    rd(12'h014, 33'h31);
    rd(12'h018, 33'h0);
    $display("test normal done");
    wrap_up();
  end
endmodule
`default_nettype wire
